// ---- hw/itd_decoder.sv ----
// Multifunction input terminal decoder with APB register access
`timescale 1ns/10ps
module itd_decoder #(
   parameter int RAMP_DIV = itd_pkg::RAMP_DIV
) (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [7:0]                        paddr,
   input  wire logic [31:0]                       pwdata,
   output logic [31:0]                            prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic [itd_pkg::ITD_NUM_TERM-1:0]  term_in,
   output itd_pkg::itd_cmd_t                      cmd,
   output logic [15:0]                            freq_ref,
   output logic [15:0]                            count_value
);

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------

   // Preset index from selects {s4,s3,s2,s1}; not a binary weight
   function automatic logic [3:0] preset_map(input logic [3:0] s);
      logic [3:0] r;
      r = 4'h0;
      case (s)
         4'b0001: r = 4'h1;
         4'b0010: r = 4'h2;
         4'b0100: r = 4'h3;
         4'b1000: r = 4'h4;
         4'b0011: r = 4'h5;
         4'b0101: r = 4'h6;
         4'b1001: r = 4'h7;
         4'b0110: r = 4'h8;
         4'b1010: r = 4'h9;
         4'b1100: r = 4'ha;
         4'b0111: r = 4'hb;
         4'b1011: r = 4'hc;
         4'b1101: r = 4'hd;
         4'b1110: r = 4'he;
         4'b1111: r = 4'hf;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   // Register index of a function-code word, or 8 if not one
   function automatic logic [3:0] func_index(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h8;
      if (a <= itd_pkg::REG_FUNC_LAST && a[1:0] == 2'b00) begin
         r = {1'b0, a[4:2]};
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [5:0]   func_q [itd_pkg::ITD_NUM_TERM];
   logic [1:0]   pid_mode_q;
   logic [15:0]  primary_q;
   logic [15:0]  fmax_q;
   logic [15:0]  fmin_q;
   logic [15:0]  jog_q;
   logic [15:0]  step_q;
   logic [15:0]  op_freq_q;
   logic [15:0]  count_q;
   logic [31:0]  rdata_q;
   logic         err_q;
   logic         reset_lvl_q;
   logic         cnt_lvl_q;
   logic         wr_en;
   logic [3:0]   wr_idx;
   logic         sel_setup;

   assign wr_en     = psel & penable & pwrite;
   assign wr_idx    = func_index(paddr);
   assign sel_setup = psel & ~penable;
   assign pready    = 1'b1;
   assign prdata    = rdata_q;
   assign pslverr   = err_q & psel & penable;

   // ------------------------------------------------------------------
   // Function code table
   // ------------------------------------------------------------------

   // One code per terminal; out-of-range codes are refused so decode stays defined
   // R22 eight terminals, codes 0-32
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < itd_pkg::ITD_NUM_TERM; i++) begin
            func_q[i] <= itd_pkg::FUNC_RST[i*6 +: 6];
         end
      end else if (wr_en && !wr_idx[3] && pwdata <= {26'h0, itd_pkg::ITD_CODE_MAX}) begin
         func_q[wr_idx[2:0]] <= pwdata[5:0];
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pid_mode_q <= itd_pkg::PID_MODE_RST;
         primary_q  <= itd_pkg::PRIMARY_RST;
         fmax_q     <= itd_pkg::FMAX_RST;
         fmin_q     <= itd_pkg::FMIN_RST;
         jog_q      <= itd_pkg::JOG_RST;
         step_q     <= itd_pkg::STEP_RST;
      end else if (wr_en) begin
         if (paddr == itd_pkg::REG_CTRL) begin
            pid_mode_q <= pwdata[1:0];
         end else if (paddr == itd_pkg::REG_PRIMARY) begin
            primary_q <= pwdata[15:0];
         end else if (paddr == itd_pkg::REG_FMAX) begin
            fmax_q <= pwdata[15:0];
         end else if (paddr == itd_pkg::REG_FMIN) begin
            fmin_q <= pwdata[15:0];
         end else if (paddr == itd_pkg::REG_JOG) begin
            jog_q <= pwdata[15:0];
         end else if (paddr == itd_pkg::REG_STEP) begin
            step_q <= pwdata[15:0];
         end
      end
   end

   // Read data captured in setup so the access phase answers at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else if (sel_setup) begin
         err_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         if (!wr_idx[3]) begin
            rdata_q <= {26'h0000000, func_q[wr_idx[2:0]]};
         end else if (paddr == itd_pkg::REG_CTRL) begin
            rdata_q <= {30'h00000000, pid_mode_q};
         end else if (paddr == itd_pkg::REG_PRIMARY) begin
            rdata_q <= {16'h0000, primary_q};
         end else if (paddr == itd_pkg::REG_FMAX) begin
            rdata_q <= {16'h0000, fmax_q};
         end else if (paddr == itd_pkg::REG_FMIN) begin
            rdata_q <= {16'h0000, fmin_q};
         end else if (paddr == itd_pkg::REG_JOG) begin
            rdata_q <= {16'h0000, jog_q};
         end else if (paddr == itd_pkg::REG_STEP) begin
            rdata_q <= {16'h0000, step_q};
         end else if (paddr == itd_pkg::REG_STATUS) begin
            rdata_q <= {14'h0000, cmd};
         end else if (paddr == itd_pkg::REG_OPFREQ) begin
            rdata_q <= {16'h0000, op_freq_q};
         end else if (paddr == itd_pkg::REG_COUNT) begin
            rdata_q <= {16'h0000, count_q};
         end else begin
            err_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Per-function activity
   // ------------------------------------------------------------------
   logic [itd_pkg::ITD_NUM_CODES-1:0] fa;

   // A function is active if any terminal carrying it is on
   // R01 code 0 ignored
   generate
      for (genvar c = 0; c < itd_pkg::ITD_NUM_CODES; c++) begin : g_fn
         logic [itd_pkg::ITD_NUM_TERM-1:0] hit;
         for (genvar t = 0; t < itd_pkg::ITD_NUM_TERM; t++) begin : g_t
            assign hit[t] = term_in[t] && (func_q[t] == 6'(c)) && (c != 0);
         end
         assign fa[c] = |hit;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------------
   logic       jog_any;
   logic       run_req;
   logic       base_rev;
   logic [3:0] preset_d;

   assign jog_any  = fa[itd_pkg::FN_JOG] | fa[itd_pkg::FN_JOG_AHEAD] | fa[itd_pkg::FN_JOG_BACK];
   // R05 run input
   assign run_req  = fa[itd_pkg::FN_AHEAD] | fa[itd_pkg::FN_BACK] | fa[itd_pkg::FN_RUN];
   // R06 forward wins a forward/reverse clash
   assign base_rev = fa[itd_pkg::FN_BACK] & ~fa[itd_pkg::FN_AHEAD];
   // R08 fixed combination table
   assign preset_d = preset_map({fa[itd_pkg::FN_SPD4], fa[itd_pkg::FN_SPD3],
                                 fa[itd_pkg::FN_SPD2], fa[itd_pkg::FN_SPD1]});

   // Motion commands; coast beats jog beats stop beats run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd.drive_en   <= 1'b1;
         cmd.run        <= 1'b0;
         cmd.reverse    <= 1'b0;
         cmd.jog        <= 1'b0;
         cmd.decel_stop <= 1'b0;
      end else begin
         // R13 coast removes drive
         cmd.drive_en   <= ~fa[itd_pkg::FN_COAST];
         // R02 jog overrides all but coast
         cmd.jog        <= jog_any & ~fa[itd_pkg::FN_COAST];
         // R23 stop decelerates
         cmd.decel_stop <= fa[itd_pkg::FN_STOP] & ~jog_any;
         // R04 forward/toggle pair
         cmd.run        <= ~fa[itd_pkg::FN_COAST] & ~fa[itd_pkg::FN_STOP] & run_req;
         if (jog_any) begin
            // R24 jog direction codes
            cmd.reverse <= fa[itd_pkg::FN_JOG_BACK] & ~fa[itd_pkg::FN_JOG_AHEAD];
         end else begin
            // R03 toggle inverts direction
            cmd.reverse <= base_rev ^ fa[itd_pkg::FN_TOGGLE];
         end
      end
   end

   // Selections and enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd.preset_idx    <= 4'h0;
         cmd.ramp_set      <= 2'h0;
         cmd.pid_en        <= 1'b0;
         cmd.seq_en        <= 1'b0;
         cmd.seq_clear     <= 1'b0;
         cmd.timer1_start  <= 1'b0;
         cmd.timer2_start  <= 1'b0;
         cmd.winding_start <= 1'b0;
      end else begin
         // R07 zero index means primary frequency
         cmd.preset_idx    <= preset_d;
         // R09 ramp pair select
         cmd.ramp_set      <= {fa[itd_pkg::FN_RAMP2], fa[itd_pkg::FN_RAMP1]};
         // R15 PID enable by contact or mode
         cmd.pid_en        <= fa[itd_pkg::FN_PID] | (pid_mode_q == itd_pkg::PID_MODE_ON);
         // R16 sequencer start
         cmd.seq_en        <= fa[itd_pkg::FN_SEQ];
         // R21 sequencer position clear
         cmd.seq_clear     <= fa[itd_pkg::FN_SEQ_CLR];
         // R17 timer starts
         cmd.timer1_start  <= fa[itd_pkg::FN_TMR1];
         cmd.timer2_start  <= fa[itd_pkg::FN_TMR2];
         // R19 winding start
         cmd.winding_start <= fa[itd_pkg::FN_WIND];
      end
   end

   // Fault reset is one pulse per activation, like a key press
   // R14 fault reset edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_lvl_q     <= 1'b0;
         cmd.fault_reset <= 1'b0;
      end else begin
         reset_lvl_q     <= fa[itd_pkg::FN_FRESET];
         cmd.fault_reset <= fa[itd_pkg::FN_FRESET] & ~reset_lvl_q;
      end
   end

   // ------------------------------------------------------------------
   // Up/down frequency
   // ------------------------------------------------------------------
   logic [$clog2(RAMP_DIV)-1:0] div_q;
   logic                        tick;
   logic [16:0]                 up_sum;
   logic [16:0]                 down_floor;

   assign tick       = (div_q == ($clog2(RAMP_DIV))'(RAMP_DIV - 1));
   assign up_sum     = {1'b0, op_freq_q} + {1'b0, step_q};
   // Widened so a large minimum plus step cannot wrap
   assign down_floor = {1'b0, fmin_q} + {1'b0, step_q};

   // Ramp rate divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else if (tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // Working frequency is volatile: reset and primary writes reload it
   // R12 changes not kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_freq_q <= itd_pkg::PRIMARY_RST;
      end else if (wr_en && paddr == itd_pkg::REG_PRIMARY) begin
         op_freq_q <= pwdata[15:0];
      end else if (tick && fa[itd_pkg::FN_UP] && !fa[itd_pkg::FN_DOWN]) begin
         // R10 rise to highest
         op_freq_q <= (up_sum >= {1'b0, fmax_q}) ? fmax_q : up_sum[15:0];
      end else if (tick && fa[itd_pkg::FN_DOWN] && !fa[itd_pkg::FN_UP]) begin
         // R11 fall to lowest
         op_freq_q <= ({1'b0, op_freq_q} <= down_floor) ? fmin_q : op_freq_q - step_q;
      end
   end

   // Reference frequency; jog speed displaces the working value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_ref <= itd_pkg::PRIMARY_RST;
      end else begin
         // R02 jog frequency
         freq_ref <= jog_any ? jog_q : op_freq_q;
      end
   end

   // ------------------------------------------------------------------
   // Pulse counter
   // ------------------------------------------------------------------

   // Rising edges counted; no filter, so the source must respect the rate
   // R18 count pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_lvl_q <= 1'b0;
         count_q   <= 16'h0000;
      end else begin
         cnt_lvl_q <= fa[itd_pkg::FN_CNT];
         // R20 clear wins over count
         if (fa[itd_pkg::FN_CNT_CLR]) begin
            count_q <= 16'h0000;
         end else if (fa[itd_pkg::FN_CNT] && !cnt_lvl_q) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   assign count_value = count_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_fresh_rise;
      fa[itd_pkg::FN_FRESET] && !reset_lvl_q;
   endsequence

   sequence s_one_pulse;
      cmd.fault_reset ##1 !cmd.fault_reset;
   endsequence

   property p_unused;
      @(posedge pclk) disable iff (!presetn)
      (fa == '0) |=> !cmd.run && !cmd.jog && cmd.drive_en;
   endproperty
   a_unused: assert property (p_unused) else $error("idle terminals gave command"); // R01

   property p_jog;
      @(posedge pclk) disable iff (!presetn)
      jog_any && !fa[itd_pkg::FN_COAST] |=> cmd.jog && (freq_ref == $past(jog_q));
   endproperty
   a_jog: assert property (p_jog) else $error("jog not applied"); // R02

   property p_pair_back;
      @(posedge pclk) disable iff (!presetn)
      fa[itd_pkg::FN_AHEAD] && fa[itd_pkg::FN_TOGGLE] && !jog_any && !fa[itd_pkg::FN_STOP]
         && !fa[itd_pkg::FN_COAST] |=> cmd.run && cmd.reverse;
   endproperty
   a_pair_back: assert property (p_pair_back) else $error("forward+toggle not reverse"); // R04

   property p_back;
      @(posedge pclk) disable iff (!presetn)
      fa[itd_pkg::FN_BACK] && !fa[itd_pkg::FN_AHEAD] && !fa[itd_pkg::FN_TOGGLE] && !jog_any
         && !fa[itd_pkg::FN_STOP] && !fa[itd_pkg::FN_COAST] |=> cmd.run && cmd.reverse;
   endproperty
   a_back: assert property (p_back) else $error("reverse not run"); // R06

   property p_preset5;
      @(posedge pclk) disable iff (!presetn)
      fa[itd_pkg::FN_SPD1] && fa[itd_pkg::FN_SPD2] && !fa[itd_pkg::FN_SPD3]
         && !fa[itd_pkg::FN_SPD4] |=> cmd.preset_idx == 4'h5;
   endproperty
   a_preset5: assert property (p_preset5) else $error("preset pair wrong"); // R08

   property p_ramp3;
      @(posedge pclk) disable iff (!presetn)
      !fa[itd_pkg::FN_RAMP1] && fa[itd_pkg::FN_RAMP2] |=> cmd.ramp_set == 2'h2;
   endproperty
   a_ramp3: assert property (p_ramp3) else $error("ramp set 3 wrong"); // R09

   property p_up;
      @(posedge pclk) disable iff (!presetn)
      tick && fa[itd_pkg::FN_UP] && !fa[itd_pkg::FN_DOWN] && !wr_en
         |=> op_freq_q <= fmax_q && op_freq_q >= $past(op_freq_q);
   endproperty
   a_up: assert property (p_up) else $error("up ramp wrong"); // R10

   property p_coast;
      @(posedge pclk) disable iff (!presetn)
      fa[itd_pkg::FN_COAST] |=> !cmd.drive_en && !cmd.run;
   endproperty
   a_coast: assert property (p_coast) else $error("coast kept drive"); // R13

   property p_freset;
      @(posedge pclk) disable iff (!presetn)
      s_fresh_rise |=> s_one_pulse;
   endproperty
   a_freset: assert property (p_freset) else $error("fault reset not a pulse"); // R14

   property p_cnt_clr;
      @(posedge pclk) disable iff (!presetn)
      fa[itd_pkg::FN_CNT_CLR] |=> count_value == 16'h0000;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("count not cleared"); // R20

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      fa[itd_pkg::FN_STOP] && !jog_any |=> cmd.decel_stop && !cmd.run;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured"); // R23

endmodule

// ---- hw/itd_pkg.sv ----
// Shared constants, register map and command carrier for the terminal decoder
// ----------------------------------------------------------------------------
// What this block does
// R01 - Terminal set to code 0 is ignored entirely.
// R02 - Code 1 runs the motor at jog frequency while active.
// R03 - Code 4 inverts the running direction while active.
// R04 - Forward plus toggle: forward alone forward, both reverse, neither stop.
// R05 - Code 5 terminal acts as the run command.
// R06 - Code 6 runs forward, code 7 runs reverse, while active.
// R07 - Codes 9 to 12 select presets; all inactive uses primary frequency.
// R08 - Select combinations map to fifteen preset speeds per fixed table.
// R09 - Codes 13 and 14 choose one of four ramp-time pairs.
// R10 - Code 15 raises operating frequency steadily up to the highest.
// R11 - Code 16 lowers operating frequency steadily down to the lowest.
// R12 - Up/down changes are not kept; reset resumes the primary setting.
// R13 - Code 17 removes drive output so the motor coasts.
// R14 - Activating code 18 clears an alarm like the keypad reset key.
// R15 - Code 19 enables PID; in mode 2 open contact disables it.
// R16 - Code 20 starts the program sequencer while closed.
// R17 - Codes 21 and 22 start timer 1 and timer 2.
// R18 - Code 23 counts pulses; source keeps rate at or below 250 Hz.
// R19 - Code 26 starts the winding operation.
// R20 - Code 24 clears the accumulated count.
// R21 - Code 25 discards saved sequencer position.
// R22 - Each of eight terminals takes any code 0 to 32.
// R23 - Code 8 decelerates the motor to a stop.
// R24 - Code 2 jogs forward, code 3 jogs reverse.
// ----------------------------------------------------------------------------
package itd_pkg;

   // Terminal count and function code space
   localparam int          ITD_NUM_TERM   = 8;
   localparam int          ITD_CODE_W     = 6;
   localparam int          ITD_NUM_CODES  = 33;
   localparam logic [5:0]  ITD_CODE_MAX   = 6'h20;

   // Function codes
   localparam int FN_JOG       = 1;
   localparam int FN_JOG_AHEAD = 2;
   localparam int FN_JOG_BACK  = 3;
   localparam int FN_TOGGLE    = 4;
   localparam int FN_RUN       = 5;
   localparam int FN_AHEAD     = 6;
   localparam int FN_BACK      = 7;
   localparam int FN_STOP      = 8;
   localparam int FN_SPD1      = 9;
   localparam int FN_SPD2      = 10;
   localparam int FN_SPD3      = 11;
   localparam int FN_SPD4      = 12;
   localparam int FN_RAMP1     = 13;
   localparam int FN_RAMP2     = 14;
   localparam int FN_UP        = 15;
   localparam int FN_DOWN      = 16;
   localparam int FN_COAST     = 17;
   localparam int FN_FRESET    = 18;
   localparam int FN_PID       = 19;
   localparam int FN_SEQ       = 20;
   localparam int FN_TMR1      = 21;
   localparam int FN_TMR2      = 22;
   localparam int FN_CNT       = 23;
   localparam int FN_CNT_CLR   = 24;
   localparam int FN_SEQ_CLR   = 25;
   localparam int FN_WIND      = 26;

   // Register byte offsets
   localparam logic [7:0] REG_FUNC_BASE  = 8'h00;
   localparam logic [7:0] REG_FUNC_LAST  = 8'h1c;
   localparam logic [7:0] REG_CTRL       = 8'h20;
   localparam logic [7:0] REG_PRIMARY    = 8'h24;
   localparam logic [7:0] REG_FMAX       = 8'h28;
   localparam logic [7:0] REG_FMIN       = 8'h2c;
   localparam logic [7:0] REG_JOG        = 8'h30;
   localparam logic [7:0] REG_STEP       = 8'h34;
   localparam logic [7:0] REG_STATUS     = 8'h38;
   localparam logic [7:0] REG_OPFREQ     = 8'h3c;
   localparam logic [7:0] REG_COUNT      = 8'h40;

   // Reset values, frequencies in 0.01 Hz
   localparam logic [47:0] FUNC_RST      = {6'h09, 6'h08, 6'h10, 6'h0f,
                                            6'h12, 6'h01, 6'h07, 6'h06};
   localparam logic [1:0]  PID_MODE_RST  = 2'h0;
   localparam logic [1:0]  PID_MODE_TERM = 2'h2;
   localparam logic [1:0]  PID_MODE_ON   = 2'h1;
   localparam logic [15:0] PRIMARY_RST   = 16'h1388;
   localparam logic [15:0] FMAX_RST      = 16'h1388;
   localparam logic [15:0] FMIN_RST      = 16'h0000;
   localparam logic [15:0] JOG_RST       = 16'h01f4;
   localparam logic [15:0] STEP_RST      = 16'h0001;

   // Up/down ramp tick period in cycles
   localparam int          RAMP_DIV      = 1000;

   // Decoded command bundle toward the drive control logic
   typedef struct packed {
      logic       drive_en;
      logic       run;
      logic       reverse;
      logic       jog;
      logic       decel_stop;
      logic       fault_reset;
      logic [3:0] preset_idx;
      logic [1:0] ramp_set;
      logic       pid_en;
      logic       seq_en;
      logic       seq_clear;
      logic       timer1_start;
      logic       timer2_start;
      logic       winding_start;
   } itd_cmd_t;

endpackage

// ---- verif/itd_decoder_bench.sv ----
// Self-checking bench for the terminal decoder
`timescale 1ns/10ps
module itd_decoder_bench;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata, rd;
   logic              pready, pslverr, err;
   logic [7:0]        term_in;
   itd_pkg::itd_cmd_t cmd;
   logic [15:0]       freq_ref, count_value;
   int                fail_count = 0;
   int                n_checks = 0;
   int                cyc = 0;
   int                hi;
   logic [3:0]        idx_tab [16] = '{0, 1, 2, 5, 3, 6, 8, 11, 4, 7, 9, 12, 10, 13, 14, 15};
   int                fn6 [6] = '{19, 20, 25, 21, 22, 26};

   itd_decoder #(.RAMP_DIV(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .term_in(term_in), .cmd(cmd),
      .freq_ref(freq_ref), .count_value(count_value));
   itd_switch_model u_sw (.pclk(pclk), .term_in(term_in));

   // Clock and hang guard
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic code(input int t, input int c);
      apb(1'b1, 8'(4 * t), 32'(c));
   endtask
   // Levels then a few edges for the one-cycle latency
   task automatic lv(input logic [7:0] v);
      u_sw.put(v);
      repeat (3) @(posedge pclk);
      #1;
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int t = 0; t < 8; t++) begin
         apb(1'b0, 8'(4 * t), 32'h0);
         chk("code", {26'h0, itd_pkg::FUNC_RST[6*t+:6]}, rd);
      end
      code(0, 33);
      apb(1'b0, 8'h00, 32'h0);
      chk("code33", 32'h6, rd);
      code(0, 69);
      apb(1'b0, 8'h00, 32'h0);
      chk("code69", 32'h6, rd);
      apb(1'b0, 8'h44, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      for (int t = 0; t < 8; t++) code(t, 0);
      lv(8'hff);
      chk("idle", 32'h20000, 32'(cmd));
      $display("test config done");
      // pair decode, toggle and run codes
      code(0, 6);
      code(1, 4);
      lv(8'h01);
      chk("ahead", 32'h2, 32'({cmd.run, cmd.reverse}));
      lv(8'h03);
      chk("toggled", 32'h3, 32'({cmd.run, cmd.reverse}));
      lv(8'h00);
      chk("off", 32'h0, 32'({cmd.run, cmd.reverse}));
      code(1, 7);
      lv(8'h02);
      chk("back", 32'h3, 32'({cmd.run, cmd.reverse}));
      code(1, 5);
      lv(8'h02);
      chk("run", 32'h2, 32'({cmd.run, cmd.reverse}));
      code(2, 8);
      lv(8'h07);
      chk("stop", 32'h1, 32'({cmd.run, cmd.decel_stop}));
      code(3, 17);
      lv(8'h09);
      chk("coast", 32'h0, 32'({cmd.drive_en, cmd.run}));
      code(0, 1);
      code(1, 2);
      code(2, 3);
      code(3, 0);
      lv(8'h01);
      chk("jog", 32'h2, 32'({cmd.jog, cmd.reverse}));
      chk("jogf", 32'h01f4, 32'(freq_ref));
      lv(8'h04);
      chk("jogback", 32'h3, 32'({cmd.jog, cmd.reverse}));
      lv(8'h02);
      chk("jogahead", 32'h2, 32'({cmd.jog, cmd.reverse}));
      $display("test direction done");
      for (int t = 0; t < 6; t++) code(t, 9 + t);
      for (int p = 0; p < 16; p++) begin
         lv(8'(p));
         chk("preset", 32'(idx_tab[p]), 32'(cmd.preset_idx));
      end
      for (int r = 0; r < 4; r++) begin
         lv(8'(r << 4));
         chk("ramp", 32'(r), 32'(cmd.ramp_set));
      end
      apb(1'b1, itd_pkg::REG_CTRL, 32'h2);
      for (int k = 0; k < 6; k++) begin
         code(0, fn6[k]);
         lv(8'h01);
         chk("en", 32'h20 >> k, 32'({cmd.pid_en, cmd.seq_en, cmd.seq_clear, cmd.timer1_start,
            cmd.timer2_start, cmd.winding_start}));
         lv(8'h00);
         chk("dis", 32'h0, 32'({cmd.pid_en, cmd.seq_en}));
      end
      apb(1'b1, itd_pkg::REG_CTRL, 32'h1);
      lv(8'h00);
      chk("pidmode", 32'h1, 32'(cmd.pid_en));
      code(0, 18);
      u_sw.put(8'h01);
      hi = 0;
      repeat (10) begin
         @(posedge pclk);
         #1;
         if (cmd.fault_reset === 1'b1) hi++;
      end
      chk("pulse", 32'h1, 32'(hi));
      $display("test functions done");
      lv(8'h00);
      code(0, 23);
      code(1, 24);
      u_sw.pulse(0, 3);
      lv(8'h00);
      chk("count", 32'h3, 32'(count_value));
      lv(8'h02);
      chk("cntclr", 32'h0, 32'(count_value));
      // up and down saturate; reset restores
      code(0, 15);
      code(1, 16);
      apb(1'b1, itd_pkg::REG_FMAX, 32'h1390);
      apb(1'b1, itd_pkg::REG_FMIN, 32'h1380);
      lv(8'h01);
      repeat (100) @(posedge pclk);
      apb(1'b0, itd_pkg::REG_OPFREQ, 32'h0);
      chk("up", 32'h1390, rd);
      lv(8'h02);
      repeat (200) @(posedge pclk);
      chk("down", 32'h1380, 32'(freq_ref));
      lv(8'h00);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, itd_pkg::REG_OPFREQ, 32'h0);
      chk("resume", 32'h1388, rd);
      $display("test frequency done");
      print_verdict();
   end
endmodule

// ---- verif/itd_switch_model.sv ----
// Model of the switches that drive the terminal inputs
`timescale 1ns/10ps
module itd_switch_model #(
   parameter int GAP = 8
) (
   input  wire logic       pclk,
   output logic      [7:0] term_in
);
   initial term_in = 8'h00;
   // Contacts move only just after a rising edge
   task automatic put(input logic [7:0] v);
      @(posedge pclk);
      term_in <= v;
   endtask
   // pulse spacing held
   // Gap shrunk for run time; a real source stays far slower
   task automatic pulse(input int b, input int n);
      repeat (n) begin
         put(term_in | (8'h01 << b));
         repeat (GAP) @(posedge pclk);
         put(term_in & ~(8'h01 << b));
         repeat (GAP) @(posedge pclk);
      end
   endtask
endmodule
